// File: hw/frpt_core.v
// Purpose: serial flash software reset sequencer and parameter read
// Assumes: serial pins are asynchronous, sampled by clk_i at 250 MHz
// Notes: mode 0 framing; sclk must stay well below clk_i / 4
`timescale 1ns/1ps
`default_nettype none
`include "frpt_defs.vh"

module frpt_core #(
    parameter [31:0] RST_CYCLES = ((`FRPT_T_RST_NS * `FRPT_CLK_MHZ) + 999) / 1000,
    parameter [31:0] RST_E_CYCLES = `FRPT_T_RST_E_US * `FRPT_CLK_MHZ,
    parameter [7:0] VENDOR_ID = 8'hA5 // Arbitrary value, set per product
) (
    input wire clk_i, // System clock
    input wire reset_i, // Synchronous reset, active high
    input wire spi_cs_n_i, // Chip select pin, active low
    input wire spi_sclk_i, // Serial clock pin
    input wire spi_si_i, // Serial data in pin
    output wire spi_so_o, // Serial data out
    output wire spi_so_oe_o, // Serial out enable, high while driving
    input wire busy_i, // Program or erase running
    input wire erase_active_i, // Erase running or suspended
    input wire latch_set_i, // Write enable latch set pulse
    input wire latch_clr_i, // Write enable latch clear pulse
    input wire susp_set_i, // Suspend flag set pulse
    input wire susp_clr_i, // Suspend flag clear pulse
    input wire vstat_wr_i, // Volatile status write strobe
    input wire [7:0] vstat_i, // Volatile status write data
    input wire rparam_wr_i, // Read parameter write strobe
    input wire [7:0] rparam_i, // Read parameter write data
    input wire mode_wr_i, // Continuous read mode write strobe
    input wire [7:0] mode_i, // Continuous read mode write data
    input wire wrap_wr_i, // Wrap setting write strobe
    input wire [2:0] wrap_i, // Wrap setting write data
    output wire abort_o, // Pulse: stop internal operation now
    output wire recovering_o, // Level: reset recovery in progress
    output wire array_suspect_o, // Level: reset hit program or erase
    output wire write_enable_latch_o, // Write enable latch
    output wire suspend_flag_o, // Program/erase suspend state
    output wire [7:0] volatile_status_o, // Volatile status bits
    output wire [7:0] read_parameter_field_o, // Read parameter setting
    output wire [7:0] continuous_read_mode_bits_o, // Continuous read mode
    output wire [2:0] wrap_setting_bits_o // Wrap setting
);

    // ********************************
    // Pin synchronisers
    // ********************************
    wire [2:0] pin_raw;
    reg [2:0] sync1_ff;
    reg [2:0] sync2_ff;
    reg [2:0] prev_ff;

    assign pin_raw = {spi_cs_n_i, spi_sclk_i, spi_si_i};

    // Two stages per pin; the edge detector only sees the second stage
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            always @(posedge clk_i) begin
                if (reset_i) begin
                    sync1_ff[gi] <= (gi == 2) ? 1'b1 : 1'b0;
                    sync2_ff[gi] <= (gi == 2) ? 1'b1 : 1'b0;
                    prev_ff[gi] <= (gi == 2) ? 1'b1 : 1'b0;
                end else begin
                    sync1_ff[gi] <= pin_raw[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                    prev_ff[gi] <= sync2_ff[gi];
                end
            end
        end
    endgenerate

    wire cs_n_s = sync2_ff[2];
    wire si_s = sync2_ff[0];
    wire cs_fall = prev_ff[2] & ~cs_n_s;
    wire cs_rise = ~prev_ff[2] & cs_n_s;
    wire sclk_rise = ~prev_ff[1] & sync2_ff[1] & ~cs_n_s;
    wire sclk_fall = prev_ff[1] & ~sync2_ff[1] & ~cs_n_s;

    // ********************************
    // Frame state
    // ********************************
    reg frm_skip_ff;
    reg [5:0] bit_cnt_ff;
    reg [7:0] opcode_ff;
    reg [23:0] addr_ff;
    reg [2:0] bit_idx_ff;
    reg so_ff;
    reg so_oe_ff;
    reg arm_ff;
    reg [31:0] rec_cnt_ff;
    reg abort_ff;
    reg suspect_ff;
    reg susp_ff;
    wire [7:0] rom_byte;

    wire recovering = (rec_cnt_ff != 32'h0000_0000);
    wire read_phase = ~frm_skip_ff & (opcode_ff == `FRPT_OP_PARAM_RD) &
                      (bit_cnt_ff == `FRPT_BITS_DATA);
    wire one_byte = (bit_cnt_ff == `FRPT_BITS_OPCODE);
    wire frm_end_ok = cs_rise & ~frm_skip_ff;
    wire enable_frame = frm_end_ok & one_byte & (opcode_ff == `FRPT_OP_RST_EN);
    wire reset_accept = frm_end_ok & one_byte & arm_ff &
                        (opcode_ff == `FRPT_OP_RST);

    // Bit counting and shift-in; frames opened in recovery are dropped whole
    always @(posedge clk_i) begin
        if (reset_i) begin
            frm_skip_ff <= 1'b1;
            bit_cnt_ff <= 6'd0;
            opcode_ff <= 8'h00;
            addr_ff <= 24'h000000;
        end else if (cs_fall) begin
            frm_skip_ff <= recovering;
            bit_cnt_ff <= 6'd0;
            opcode_ff <= 8'h00;
            addr_ff <= 24'h000000;
        end else if (sclk_rise & ~frm_skip_ff) begin
            if (bit_cnt_ff < `FRPT_BITS_DATA) begin
                bit_cnt_ff <= bit_cnt_ff + 6'd1;
            end
            if (bit_cnt_ff < `FRPT_BITS_OPCODE) begin
                opcode_ff <= {opcode_ff[6:0], si_s};
            end else if (bit_cnt_ff < `FRPT_BITS_ADDR_END) begin
                addr_ff <= {addr_ff[22:0], si_s};
            end
        end else if (sclk_fall & read_phase & (bit_idx_ff == 3'd0)) begin
            addr_ff <= addr_ff + 24'h000001;
        end
    end

    // ********************************
    // Parameter stream out
    // ********************************
    frpt_param_rom #(
        .VENDOR_ID(VENDOR_ID)
    ) u_rom (
        .addr_i(addr_ff),
        .data_o(rom_byte)
    );

    // Shift out on falling sclk, MSB first; host samples on rising edge
    always @(posedge clk_i) begin
        if (reset_i | cs_fall | cs_rise) begin
            bit_idx_ff <= 3'd7;
            so_ff <= 1'b0;
            so_oe_ff <= 1'b0;
        end else if (sclk_fall & read_phase) begin
            so_ff <= rom_byte[bit_idx_ff];
            so_oe_ff <= 1'b1;
            bit_idx_ff <= bit_idx_ff - 3'd1;
        end
    end

    assign spi_so_o = so_ff;
    assign spi_so_oe_o = so_oe_ff;

    // ********************************
    // Reset sequencer
    // ********************************
    // Enable arms only for the very next frame; any other frame disarms
    always @(posedge clk_i) begin
        if (reset_i) begin
            arm_ff <= 1'b0;
        end else if (frm_end_ok) begin
            arm_ff <= enable_frame;
        end
    end

    // Recovery timer; longer when an erase was cut short
    always @(posedge clk_i) begin
        if (reset_i) begin
            rec_cnt_ff <= 32'h0000_0000;
        end else if (reset_accept) begin
            rec_cnt_ff <= erase_active_i ? RST_E_CYCLES : RST_CYCLES;
        end else if (recovering) begin
            rec_cnt_ff <= rec_cnt_ff - 32'h0000_0001;
        end
    end

    // Abort pulse, and a sticky warning that array contents may be bad
    always @(posedge clk_i) begin
        if (reset_i) begin
            abort_ff <= 1'b0;
            suspect_ff <= 1'b0;
        end else begin
            abort_ff <= reset_accept;
            if (reset_accept & (busy_i | erase_active_i | susp_ff)) begin
                suspect_ff <= 1'b1;
            end
        end
    end

    assign abort_o = abort_ff;
    assign recovering_o = recovering;
    assign array_suspect_o = suspect_ff;

    // ********************************
    // Volatile state
    // ********************************
    reg latch_ff;
    reg [7:0] vstat_ff;
    reg [7:0] rparam_ff;
    reg [7:0] mode_ff;
    reg [2:0] wrap_ff;
    wire upd_ok = ~recovering;

    // Accepted reset beats every update; set beats clear on the flags
    always @(posedge clk_i) begin
        if (reset_i | reset_accept) begin
            latch_ff <= 1'b0;
            susp_ff <= 1'b0;
            vstat_ff <= 8'h00;
            rparam_ff <= 8'h00;
            mode_ff <= 8'h00;
            wrap_ff <= 3'b000;
        end else if (upd_ok) begin
            if (latch_set_i) begin
                latch_ff <= 1'b1;
            end else if (latch_clr_i) begin
                latch_ff <= 1'b0;
            end
            if (susp_set_i) begin
                susp_ff <= 1'b1;
            end else if (susp_clr_i) begin
                susp_ff <= 1'b0;
            end
            if (vstat_wr_i) begin
                vstat_ff <= vstat_i;
            end
            if (rparam_wr_i) begin
                rparam_ff <= rparam_i;
            end
            if (mode_wr_i) begin
                mode_ff <= mode_i;
            end
            if (wrap_wr_i) begin
                wrap_ff <= wrap_i;
            end
        end
    end

    assign write_enable_latch_o = latch_ff;
    assign suspend_flag_o = susp_ff;
    assign volatile_status_o = vstat_ff;
    assign read_parameter_field_o = rparam_ff;
    assign continuous_read_mode_bits_o = mode_ff;
    assign wrap_setting_bits_o = wrap_ff;

endmodule
`default_nettype wire

// File: inc/frpt_defs.vh
// Purpose: constants for the flash reset and parameter table block
// Assumes: 250 MHz system clock, serial mode 0 framing
// Notes: definitions only, no logic
`ifndef FRPT_DEFS_VH
`define FRPT_DEFS_VH

// ********************************
// Opcodes
// ********************************
`define FRPT_OP_RST_EN 8'h66
`define FRPT_OP_RST 8'h99
`define FRPT_OP_PARAM_RD 8'h5A

// ********************************
// Frame bit positions
// ********************************
`define FRPT_BITS_OPCODE 6'd8
`define FRPT_BITS_ADDR_END 6'd32
`define FRPT_BITS_DATA 6'd40

// ********************************
// Timing
// ********************************
`define FRPT_CLK_MHZ 250
`define FRPT_T_RST_NS 30000
`define FRPT_T_RST_E_US 12000

// ********************************
// Parameter area contents
// ********************************
`define FRPT_FILL 8'hFF
`define FRPT_SIG0 8'h53
`define FRPT_SIG1 8'h46
`define FRPT_SIG2 8'h44
`define FRPT_SIG3 8'h50
`define FRPT_REV_MINOR 8'h00
`define FRPT_REV_MAJOR 8'h01
`define FRPT_NUM_HDR 8'h01
`define FRPT_STD_ID 8'h00
`define FRPT_STD_LEN 8'h09
`define FRPT_VND_LEN 8'h03
`define FRPT_STD_PTR 8'h30
`define FRPT_VND_PTR 8'h60
`define FRPT_PTR_HI 8'h00
`define FRPT_ERASE_4K 2'b01
`define FRPT_WR_GRAN 1'b1
`define FRPT_BP_VOL 1'b0
`define FRPT_WREN_SEL 1'b0
`define FRPT_UNUSED3 3'b111
`define FRPT_OP_ERASE_4K 8'h20
`define FRPT_ADDR_BYTES 2'b00
`define FRPT_DTR 1'b0
`define FRPT_QIO_WAIT 5'b00100
`define FRPT_QIO_MODE 3'b010
`define FRPT_QIO_OP 8'hEB
`define FRPT_QO_WAIT 5'b01000
`define FRPT_QO_MODE 3'b000
`define FRPT_QO_OP 8'h6B

`endif

// File: hw/frpt_param_rom.v
// Purpose: read-only discoverable parameter area, byte wide
// Assumes: area sits in the lowest 256 bytes of the parameter space
// Notes: every byte not listed reads as fill, nothing here is writable
`timescale 1ns/1ps
`default_nettype none
`include "frpt_defs.vh"

module frpt_param_rom #(
    parameter [7:0] VENDOR_ID = 8'hA5 // Arbitrary value, set per product
) (
    input wire [23:0] addr_i, // Byte address
    output reg [7:0] data_o // Byte at that address
);

    // Table lookup; words are little-endian, low address holds bits 7:0
    always @* begin
        data_o = `FRPT_FILL;
        if (addr_i[23:8] == 16'h0000) begin
            case (addr_i[7:0])
                8'h00: data_o = `FRPT_SIG0;
                8'h01: data_o = `FRPT_SIG1;
                8'h02: data_o = `FRPT_SIG2;
                8'h03: data_o = `FRPT_SIG3;
                8'h04: data_o = `FRPT_REV_MINOR;
                8'h05: data_o = `FRPT_REV_MAJOR;
                8'h06: data_o = `FRPT_NUM_HDR;
                8'h08: data_o = `FRPT_STD_ID;
                8'h09: data_o = `FRPT_REV_MINOR;
                8'h0A: data_o = `FRPT_REV_MAJOR;
                8'h0B: data_o = `FRPT_STD_LEN;
                8'h0C: data_o = `FRPT_STD_PTR;
                8'h0D: data_o = `FRPT_PTR_HI;
                8'h0E: data_o = `FRPT_PTR_HI;
                8'h10: data_o = VENDOR_ID;
                8'h11: data_o = `FRPT_REV_MINOR;
                8'h12: data_o = `FRPT_REV_MAJOR;
                8'h13: data_o = `FRPT_VND_LEN;
                8'h14: data_o = `FRPT_VND_PTR;
                8'h15: data_o = `FRPT_PTR_HI;
                8'h16: data_o = `FRPT_PTR_HI;
                // First standard word, low byte: unused top bits read ones
                8'h30: data_o = {`FRPT_UNUSED3, `FRPT_WREN_SEL, `FRPT_BP_VOL,
                                 `FRPT_WR_GRAN, `FRPT_ERASE_4K};
                8'h31: data_o = `FRPT_OP_ERASE_4K;
                // Read support bits 23:16: unused, quad out, quad io, dual io
                8'h32: data_o = {1'b1, 1'b1, 1'b1, 1'b1, `FRPT_DTR,
                                 `FRPT_ADDR_BYTES, 1'b1};
                8'h38: data_o = {`FRPT_QIO_MODE, `FRPT_QIO_WAIT};
                8'h39: data_o = `FRPT_QIO_OP;
                8'h3A: data_o = {`FRPT_QO_MODE, `FRPT_QO_WAIT};
                8'h3B: data_o = `FRPT_QO_OP;
                default: data_o = `FRPT_FILL;
            endcase
        end
    end

endmodule
`default_nettype wire

// File: dv/frpt_monitor.sv
// Purpose: port checker for frpt_core
// Assumes: one clock, reset_i synchronous and active high
// Notes: bound to every frpt_core at the end of this file
`timescale 1ns/1ps
`default_nettype none
module frpt_monitor #(
    parameter [31:0] RST_CYCLES = 32'd20,
    parameter [31:0] RST_E_CYCLES = 32'd60
) (
    input wire clk_i, // Clock
    input wire reset_i, // Reset
    input wire spi_cs_n_i, // Chip select
    input wire busy_i, // Program or erase running
    input wire erase_active_i, // Erase running or suspended
    input wire latch_set_i, // Latch set pulse
    input wire abort_o, // Abort pulse
    input wire recovering_o, // Recovery level
    input wire array_suspect_o, // Suspect array flag
    input wire spi_so_oe_o, // Output enable
    input wire write_enable_latch_o, // Write enable latch
    input wire suspend_flag_o, // Suspend state
    input wire [7:0] volatile_status_o, // Volatile status
    input wire [7:0] read_parameter_field_o, // Read parameter
    input wire [7:0] continuous_read_mode_bits_o, // Mode bits
    input wire [2:0] wrap_setting_bits_o // Wrap setting
);
    logic [31:0] rec_cnt_ff;
    logic long_ff;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // Recovery length, restarted by each abort so a stale count never leaks
    always @(posedge clk_i) begin
        if (reset_i) begin
            rec_cnt_ff <= 32'h0;
            long_ff <= 1'b0;
        end else if (abort_o) begin
            rec_cnt_ff <= 32'h1;
            long_ff <= $past(erase_active_i);
        end else if (recovering_o) begin
            rec_cnt_ff <= rec_cnt_ff + 32'h1;
        end
    end
    sequence s_accept;
        abort_o && recovering_o;
    endsequence
    sequence s_cs_idle;
        spi_cs_n_i [*5];
    endsequence
    a_abort_single_pulse: assert property (abort_o |=> !abort_o)
        else $error("abort wider than one cycle");
    a_abort_starts_recovery: assert property (abort_o |-> s_accept)
        else $error("abort without recovery");
    a_reset_clears_flags: assert property (s_accept |-> !write_enable_latch_o
        && !suspend_flag_o && volatile_status_o == 8'h00) else $error("flags kept");
    a_reset_clears_fields: assert property (s_accept |-> read_parameter_field_o == 8'h00
        && continuous_read_mode_bits_o == 8'h00 && wrap_setting_bits_o == 3'h0)
        else $error("fields kept");
    a_recovery_holds_state: assert property (recovering_o |=>
        $stable(write_enable_latch_o) && $stable(wrap_setting_bits_o))
        else $error("state changed in recovery");
    a_latch_set_takes: assert property (latch_set_i && !recovering_o |=>
        write_enable_latch_o || abort_o) else $error("latch set lost");
    a_suspect_on_busy: assert property (abort_o && $past(busy_i) |-> ##[0:1] array_suspect_o)
        else $error("suspect flag missing");
    a_suspect_sticky: assert property (array_suspect_o |=> array_suspect_o)
        else $error("suspect flag dropped");
    a_oe_off_idle: assert property (s_cs_idle |-> !spi_so_oe_o)
        else $error("output driven while deselected");
    a_recovery_length: assert property ($fell(recovering_o) |->
        rec_cnt_ff == (long_ff ? RST_E_CYCLES : RST_CYCLES)) else $error("recovery length");
endmodule
bind frpt_core frpt_monitor #(.RST_CYCLES(RST_CYCLES), .RST_E_CYCLES(RST_E_CYCLES))
    frpt_monitor_i (.*);
`default_nettype wire

// File: dv/frpt_host.sv
// Purpose: serial host model driving the flash pins
// Assumes: mode 0, link clock of 32 ns made from eight clk_i cycles
// Notes: link clock rests low between frames; idle data line toggles
`timescale 1ns/1ps
`default_nettype none
module frpt_host (
    input wire logic clk_i, // System clock
    input wire logic so_i, // Serial data from device
    input wire logic so_oe_i, // Device output enable
    output logic cs_n_o, // Chip select, active low
    output logic sclk_o, // Link clock
    output logic si_o // Serial data to device
);
    logic [7:0] rx_q[$];
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
    end
    // Half link period
    task half;
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    // Header MSB first, eight dummy clocks before any read bytes
    task frame(input logic [31:0] hdr, input int nhdr, input int nrd);
        int tot;
        logic [7:0] sh;
        tot = nhdr + ((nrd > 0) ? 8 + 8 * nrd : 0);
        rx_q = {};
        sh = 8'h00;
        half();
        cs_n_o = 1'b0;
        for (int i = 0; i < tot; i++) begin
            si_o = (i < nhdr) ? hdr[nhdr - 1 - i] : ~si_o;
            half();
            sclk_o = 1'b1;
            half();
            // Sampled late in the high phase, after the device updates
            if (i >= nhdr + 8) begin
                // Released line reads inverted, so an undriven bit cannot pass
                sh = {sh[6:0], so_oe_i ? so_i : ~so_i};
                if ((i - nhdr) % 8 == 7) rx_q.push_back(sh);
            end
            sclk_o = 1'b0;
        end
        half();
        cs_n_o = 1'b1;
        si_o = ~si_o;
        half();
        half();
    endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
// Purpose: self-checking bench for frpt_core
// Assumes: recovery counts shortened through parameters
// Notes: host model drives the serial pins
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int RC = 20;
    localparam int REC = 60;
    localparam logic [7:0] VID = 8'h3C; // Arbitrary maker code
    logic clk_i, reset_i, busy_i, erase_active_i, latch_set_i, latch_clr_i, susp_set_i;
    logic susp_clr_i, vstat_wr_i, rparam_wr_i, mode_wr_i, wrap_wr_i, oe_seen;
    logic [7:0] vstat_i, rparam_i, mode_i;
    logic [2:0] wrap_i;
    logic [31:0] aborts, rec_len;
    wire spi_cs_n_i, spi_sclk_i, spi_si_i, spi_so_o, spi_so_oe_o, abort_o, recovering_o;
    wire array_suspect_o, write_enable_latch_o, suspend_flag_o;
    wire [7:0] volatile_status_o, read_parameter_field_o, continuous_read_mode_bits_o;
    wire [2:0] wrap_setting_bits_o;
    int num_errors = 0;
    int cmp_count = 0;
    frpt_core #(.RST_CYCLES(RC), .RST_E_CYCLES(REC), .VENDOR_ID(VID)) frpt_core_i (.*);
    frpt_host frpt_host_i (.clk_i(clk_i), .so_i(spi_so_o), .so_oe_i(spi_so_oe_o),
        .cs_n_o(spi_cs_n_i), .sclk_o(spi_sclk_i), .si_o(spi_si_i));
    // ********************************
    // Observers and shared tasks
    // ********************************
    always @(posedge clk_i) begin
        aborts <= reset_i ? 32'h0 : aborts + abort_o;
        rec_len <= abort_o ? 32'h1 : rec_len + recovering_o;
        if (spi_so_oe_o) oe_seen <= 1'b1;
    end
    task tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Every volatile field written at once
    task load_state;
        {vstat_i, rparam_i, mode_i, wrap_i} = {8'hA6, 8'h5C, 8'hB3, 3'h5};
        {latch_set_i, susp_set_i, vstat_wr_i, rparam_wr_i, mode_wr_i, wrap_wr_i} = 6'h3F;
        tick(1);
        {latch_set_i, susp_set_i, vstat_wr_i, rparam_wr_i, mode_wr_i, wrap_wr_i} = 6'h00;
        tick(1);
    endtask
    task rst_pair;
        frpt_host_i.frame(32'h66, 8, 0);
        frpt_host_i.frame(32'h99, 8, 0);
    endtask
    // Header area from zero, then the first table words
    task s_param;
        logic [7:0] exp[$];
        exp = {8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF, 8'h00, 8'h00, 8'h01,
            8'h09, 8'h30, 8'h00, 8'h00, 8'hFF, VID, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00,
            8'hFF, 8'hE5, 8'h20, 8'hF1, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h44, 8'hEB,
            8'h08, 8'h6B};
        frpt_host_i.frame({8'h5A, 24'h000000}, 32, 24);
        for (int i = 0; i < 24; i++) chk("header byte", exp[i], frpt_host_i.rx_q[i]);
        frpt_host_i.frame({8'h5A, 24'h000030}, 32, 12);
        for (int i = 0; i < 12; i++) chk("table byte", exp[24 + i], frpt_host_i.rx_q[i]);
        chk("oe in read", 1, oe_seen);
    endtask
    // Lone, disarmed and overlong frames must not reset
    task s_disarm;
        load_state();
        frpt_host_i.frame(32'h99, 8, 0);
        frpt_host_i.frame(32'h66, 8, 0);
        frpt_host_i.frame({8'h5A, 24'h0}, 32, 1);
        frpt_host_i.frame(32'h99, 8, 0);
        frpt_host_i.frame(32'h0CC, 9, 0);
        frpt_host_i.frame(32'h99, 8, 0);
        chk("abort count", 0, aborts);
        chk("latch kept", 1, write_enable_latch_o);
        // Set beats clear on the latch; clear alone drops the suspend flag
        {latch_set_i, latch_clr_i, susp_clr_i} = 3'b111;
        tick(1);
        {latch_set_i, latch_clr_i, susp_clr_i} = 3'b000;
        tick(1);
        chk("set over clear", 2'b10, {write_enable_latch_o, suspend_flag_o});
    endtask
    // Accepted reset with suspend set, strobe and read during recovery
    task s_reset;
        load_state();
        chk("state loaded", {2'b11, 8'hA6, 8'h5C, 8'hB3, 3'h5}, {write_enable_latch_o,
            suspend_flag_o, volatile_status_o, read_parameter_field_o,
            continuous_read_mode_bits_o, wrap_setting_bits_o});
        busy_i = 1'b0; // Busy clear before the sequence
        rst_pair();
        chk("abort count", 1, aborts);
        chk("recovering", 1, recovering_o);
        chk("suspect", 1, array_suspect_o);
        chk("volatile", 0, {write_enable_latch_o, suspend_flag_o, volatile_status_o,
            read_parameter_field_o, continuous_read_mode_bits_o, wrap_setting_bits_o});
        latch_set_i = 1'b1;
        tick(1);
        latch_set_i = 1'b0;
        oe_seen = 1'b0;
        frpt_host_i.frame({8'h5A, 24'h0}, 32, 1);
        chk("oe in recovery", 0, oe_seen);
        chk("latch in recovery", 0, write_enable_latch_o);
        chk("recovery length", RC, rec_len);
    endtask
    // Reset hitting a busy erase takes the long recovery
    task s_long;
        reset_i = 1'b1;
        tick(3);
        reset_i = 1'b0;
        {busy_i, erase_active_i} = 2'b11;
        tick(4);
        chk("suspect cleared", 0, array_suspect_o);
        rst_pair();
        chk("suspect", 1, array_suspect_o);
        tick(REC + 4);
        chk("long recovery", REC, rec_len);
        chk("recovering", 0, recovering_o);
        {busy_i, erase_active_i} = 2'b00;
    endtask
    task report_and_stop;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        {reset_i, busy_i, erase_active_i, latch_set_i, latch_clr_i, susp_set_i} = 6'h20;
        {susp_clr_i, vstat_wr_i, rparam_wr_i, mode_wr_i, wrap_wr_i, oe_seen} = 6'h00;
        {vstat_i, rparam_i, mode_i, wrap_i} = 27'h0;
        tick(16);
        reset_i = 1'b0;
        tick(4);
        s_param();
        s_disarm();
        s_reset();
        s_long();
        report_and_stop();
    end
    // Watchdog well beyond the expected run of about 18 us
    initial begin
        #200000;
        num_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
